// file: logic/dct_pkg.sv
package dct_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] OFS_BANK_PTR = 8'hfd;
  localparam logic [3:0] WORK_GRP_ALIAS = 4'he;
  localparam logic [3:0] BANK_NORMAL = 4'h0;
  localparam logic [3:0] BANK_TIMER = 4'hd;
  localparam logic [3:0] OFS_T8_CTL = 4'h0;
  localparam logic [3:0] OFS_IO_CTL = 4'h1;
  localparam logic [3:0] OFS_T16_CTL = 4'h2;
  localparam logic [3:0] OFS_SHARED_CTL = 4'h3;
  localparam logic [3:0] OFS_T8_LOW = 4'h4;
  localparam logic [3:0] OFS_T8_HIGH = 4'h5;
  localparam logic [3:0] OFS_T16_LOW = 4'h6;
  localparam logic [3:0] OFS_T16_HIGH = 4'h7;
  // ==========================================================
  // field positions
  localparam int B_EN = 7;
  localparam int B_SINGLE = 6;
  localparam int B_TOUT = 5;
  localparam int B_CLK_LO = 3;
  localparam int B_CAP_IE = 2;
  localparam int B_TO_IE = 1;
  localparam int B_T8_IE = 1;
  localparam int B_EDGE_LO = 4;
  localparam int B_GLITCH_LO = 2;
  localparam int B_INIT_LVL = 1;
  // ==========================================================
  // reset values and constants
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] SHARED_RSVD = 5'h1f;
  localparam logic [15:0] T16_MAX = 16'hffff;
  localparam logic [3:0] DIV16_LAST = 4'hf;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // glitch filter accept counts: widths of 1, 4, 8, 16 cycles
  localparam logic [3:0] GF_LIM0 = 4'h0;
  localparam logic [3:0] GF_LIM1 = 4'h3;
  localparam logic [3:0] GF_LIM2 = 4'h7;
  localparam logic [3:0] GF_LIM3 = 4'hf;
  // bits kept through stop-mode recovery
  localparam logic [7:0] T8_CTL_KEEP = 8'h3c;
  localparam logic [7:0] IO_CTL_KEEP = 8'h30;
  localparam logic [7:0] T16_CTL_KEEP = 8'h20;
endpackage : dct_pkg

// file: logic/dct_timer.sv
`timescale 1ns/100ps
// Overview of operation
// - bank pointer upper nibble picks working group
// - lower nibble D swaps in expanded timer bank
// - bit7 enables, bit6 single pass or modulo
// - bit5 timeout flag write-one-clear; bits4:3 prescale
// - short-control capture interrupt enable survives stop recovery; long-control one clears
// - high hold reloads while output high
// - low hold reloads while output low
// - long hold pair is capture data; long counter reloads to maximum
// - shared control bits4:0 read ones, ignore writes
// - edge detector emits selected edge pulse
// - glitch filter drops pulses below chosen width
// - idle short output is inverse of level bit
// - single mode ignores later edges, keeps counting
// - in long single mode, short timeout captures long count, interrupts
// - timeout capture does not reload long counter
// - rewriting bit6 zero-then-one rearms one capture
// - long counter wraps to maximum at zero
// - wrap sets status bit, optional timeout interrupt
// - single pass loads hold by output level
// - count clock from system clock, optional /16
module dct_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // system control
  input wire logic smr_recover_i,
  input wire logic sclk_div16_i,
  // capture input and transmit output
  input wire logic cap_in_i,
  output logic short_counter_output_o,
  // interrupt requests
  output logic t8_irq_o,
  output logic cap_irq_o,
  output logic tmo_irq_o
);
  // ==========================================================
  // register decode
  logic [7:0] bank_pointer_ff;
  logic [7:0] eff_addr;
  logic bank_hit;
  logic [3:0] reg_sel;
  logic [7:0] timer8_control_ff, timer_io_control_ff, timer16_control_ff;
  logic [2:0] shared_hi_ff;
  logic [7:0] timer8_low_hold_ff, timer8_high_hold_ff;
  logic [7:0] timer16_low_hold_ff, timer16_high_hold_ff;
  logic [7:0] rd_data_ff;

  // working-register alias maps through the group nibble
  assign eff_addr = (addr_i[7:4] == dct_pkg::WORK_GRP_ALIAS) ?
    {bank_pointer_ff[7:4], addr_i[3:0]} : addr_i;
  // only the timer bank lives here; bank 0/F go elsewhere
  assign bank_hit = (eff_addr[7:4] == 4'h0) &&
    (bank_pointer_ff[3:0] == dct_pkg::BANK_TIMER);
  assign reg_sel = eff_addr[3:0];

  function automatic logic wr_to(input logic [3:0] ofs);
    wr_to = wr_i && bank_hit && (reg_sel == ofs);
  endfunction : wr_to

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bank_pointer_ff <= dct_pkg::RST_BYTE;
    end else if (wr_i && eff_addr == dct_pkg::OFS_BANK_PTR) begin
      bank_pointer_ff <= wdata_i;
    end
  end

  // ==========================================================
  // prescaler
  logic [3:0] div16_ff;
  logic [2:0] pre8_ff;
  logic base_tick, t8_tick;
  logic [2:0] pre_mask;

  assign base_tick = !sclk_div16_i ||
    (div16_ff == dct_pkg::DIV16_LAST);
  assign pre_mask = 3'((4'h1 << timer8_control_ff[4:3]) - 4'h1);
  assign t8_tick = base_tick && ((pre8_ff & pre_mask) == pre_mask);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div16_ff <= 4'h0;
      pre8_ff <= 3'h0;
    end else begin
      div16_ff <= div16_ff + 4'h1;
      if (base_tick) begin
        pre8_ff <= pre8_ff + 3'h1;
      end
    end
  end

  // ==========================================================
  // input glitch filter and edge detector
  logic filt_ff;
  logic [3:0] gcnt_ff;
  logic [3:0] glim;
  logic filt_chg, edge_sel;

  always_comb begin
    case (timer_io_control_ff[3:2])
      2'h0: glim = dct_pkg::GF_LIM0;
      2'h1: glim = dct_pkg::GF_LIM1;
      2'h2: glim = dct_pkg::GF_LIM2;
      default: glim = dct_pkg::GF_LIM3;
    endcase
  end

  // level must differ for glim+1 cycles before it is believed
  assign filt_chg = (cap_in_i != filt_ff) && (gcnt_ff == glim);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      filt_ff <= 1'b0;
      gcnt_ff <= 4'h0;
    end else if (cap_in_i == filt_ff || filt_chg) begin
      filt_ff <= cap_in_i;
      gcnt_ff <= 4'h0;
    end else begin
      gcnt_ff <= gcnt_ff + 4'h1;
    end
  end

  always_comb begin
    case (timer_io_control_ff[5:4])
      dct_pkg::EDGE_RISE: edge_sel = filt_chg && cap_in_i;
      dct_pkg::EDGE_FALL: edge_sel = filt_chg && !cap_in_i;
      dct_pkg::EDGE_BOTH: edge_sel = filt_chg;
      default: edge_sel = 1'b0;
    endcase
  end

  // ==========================================================
  // short counter
  logic [7:0] short_counter_ff;
  logic t8_en_q_ff, short_counter_output_ff, t8_to, t8_start;
  logic [7:0] t8_load;

  assign t8_start = timer8_control_ff[dct_pkg::B_EN] && !t8_en_q_ff;
  assign t8_to = timer8_control_ff[dct_pkg::B_EN] && !t8_start &&
    t8_tick && (short_counter_ff == 8'h00);
  // reload value follows the level the output will hold next
  assign t8_load = (t8_start ? short_counter_output_ff : !short_counter_output_ff) ?
    timer8_high_hold_ff : timer8_low_hold_ff;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      short_counter_ff <= 8'h00;
      t8_en_q_ff <= 1'b0;
      short_counter_output_ff <= 1'b1;
    end else begin
      t8_en_q_ff <= timer8_control_ff[dct_pkg::B_EN];
      if (!timer8_control_ff[dct_pkg::B_EN]) begin
        short_counter_output_ff <= !timer_io_control_ff[dct_pkg::B_INIT_LVL];
      end else if (t8_start || t8_to) begin
        short_counter_ff <= t8_load;
        if (t8_to) begin
          short_counter_output_ff <= !short_counter_output_ff;
        end
      end else if (t8_tick) begin
        short_counter_ff <= short_counter_ff - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      timer8_control_ff <= dct_pkg::RST_BYTE;
    end else if (smr_recover_i) begin
      timer8_control_ff <= timer8_control_ff &
        dct_pkg::T8_CTL_KEEP;
    end else begin
      if (wr_to(dct_pkg::OFS_T8_CTL)) begin
        timer8_control_ff <= {wdata_i[7:6],
          timer8_control_ff[5] && !wdata_i[5], wdata_i[4:0]};
      end
      // hardware set wins over the write-one clear
      if (t8_to) begin
        timer8_control_ff[dct_pkg::B_TOUT] <= 1'b1;
        if (timer8_control_ff[dct_pkg::B_SINGLE]) begin
          timer8_control_ff[dct_pkg::B_EN] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // long counter, demodulation
  logic [15:0] long_counter_ff;
  logic arm_ff, edge_cap, t8_cap, t16_wrap, t16_run;

  assign t16_run = timer16_control_ff[dct_pkg::B_EN];
  // single mode takes only the first edge after arming
  assign edge_cap = t16_run && edge_sel &&
    (!timer16_control_ff[dct_pkg::B_SINGLE] || arm_ff);
  assign t8_cap = t16_run && timer16_control_ff[dct_pkg::B_SINGLE] &&
    t8_to && !edge_cap;
  assign t16_wrap = t16_run && !edge_cap && base_tick &&
    (long_counter_ff == 16'h0000);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      arm_ff <= 1'b1;
    end else if (wr_to(dct_pkg::OFS_T16_CTL) && wdata_i[dct_pkg::B_SINGLE] &&
        !timer16_control_ff[dct_pkg::B_SINGLE]) begin
      arm_ff <= 1'b1;
    end else if (edge_cap) begin
      arm_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      long_counter_ff <= dct_pkg::T16_MAX;
    end else if (edge_cap) begin
      long_counter_ff <= dct_pkg::T16_MAX;
    end else if (t16_run && base_tick) begin
      // t8 capture leaves the count running; zero wraps to max
      long_counter_ff <= long_counter_ff - 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      timer16_control_ff <= dct_pkg::RST_BYTE;
    end else if (smr_recover_i) begin
      timer16_control_ff <= timer16_control_ff & dct_pkg::T16_CTL_KEEP;
    end else begin
      if (wr_to(dct_pkg::OFS_T16_CTL)) begin
        timer16_control_ff <= {wdata_i[7:6],
          timer16_control_ff[5] && !wdata_i[5], wdata_i[4:0]};
      end
      if (t16_wrap) begin
        timer16_control_ff[dct_pkg::B_TOUT] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // hold and control registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      timer_io_control_ff <= dct_pkg::RST_BYTE;
    end else if (smr_recover_i) begin
      timer_io_control_ff <= timer_io_control_ff & dct_pkg::IO_CTL_KEEP;
    end else if (wr_to(dct_pkg::OFS_IO_CTL)) begin
      timer_io_control_ff <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || smr_recover_i) begin
      shared_hi_ff <= 3'h0;
    end else if (wr_to(dct_pkg::OFS_SHARED_CTL)) begin
      shared_hi_ff <= wdata_i[7:5];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      timer8_low_hold_ff <= dct_pkg::RST_BYTE;
      timer8_high_hold_ff <= dct_pkg::RST_BYTE;
    end else begin
      if (wr_to(dct_pkg::OFS_T8_LOW)) begin
        timer8_low_hold_ff <= wdata_i;
      end
      if (wr_to(dct_pkg::OFS_T8_HIGH)) begin
        timer8_high_hold_ff <= wdata_i;
      end
    end
  end

  // a capture outranks a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      timer16_low_hold_ff <= dct_pkg::RST_BYTE;
      timer16_high_hold_ff <= dct_pkg::RST_BYTE;
    end else if (edge_cap || t8_cap) begin
      {timer16_high_hold_ff, timer16_low_hold_ff} <= long_counter_ff;
    end else begin
      if (wr_to(dct_pkg::OFS_T16_LOW)) begin
        timer16_low_hold_ff <= wdata_i;
      end
      if (wr_to(dct_pkg::OFS_T16_HIGH)) begin
        timer16_high_hold_ff <= wdata_i;
      end
    end
  end

  // ==========================================================
  // read port and interrupt pulses
  logic t8_irq_ff, cap_irq_ff, tmo_irq_ff;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_data_ff <= dct_pkg::RST_BYTE;
    end else if (rd_i) begin
      rd_data_ff <= dct_pkg::RST_BYTE;
      if (eff_addr == dct_pkg::OFS_BANK_PTR) begin
        rd_data_ff <= bank_pointer_ff;
      end else if (bank_hit) begin
        case (reg_sel)
          dct_pkg::OFS_T8_CTL: rd_data_ff <= timer8_control_ff;
          dct_pkg::OFS_IO_CTL: rd_data_ff <= timer_io_control_ff;
          dct_pkg::OFS_T16_CTL: rd_data_ff <= timer16_control_ff;
          dct_pkg::OFS_SHARED_CTL:
            rd_data_ff <= {shared_hi_ff, dct_pkg::SHARED_RSVD};
          dct_pkg::OFS_T8_LOW: rd_data_ff <= timer8_low_hold_ff;
          dct_pkg::OFS_T8_HIGH: rd_data_ff <= timer8_high_hold_ff;
          dct_pkg::OFS_T16_LOW: rd_data_ff <= timer16_low_hold_ff;
          dct_pkg::OFS_T16_HIGH: rd_data_ff <= timer16_high_hold_ff;
          default: rd_data_ff <= dct_pkg::RST_BYTE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      t8_irq_ff <= 1'b0;
      cap_irq_ff <= 1'b0;
      tmo_irq_ff <= 1'b0;
    end else begin
      t8_irq_ff <= t8_to && timer8_control_ff[dct_pkg::B_T8_IE];
      cap_irq_ff <= (edge_cap && timer8_control_ff[dct_pkg::B_CAP_IE]) ||
        (t8_cap && timer16_control_ff[dct_pkg::B_CAP_IE]);
      tmo_irq_ff <= t16_wrap && timer16_control_ff[dct_pkg::B_TO_IE];
    end
  end

  assign rdata_o = rd_data_ff;
  assign short_counter_output_o = short_counter_output_ff;
  assign t8_irq_o = t8_irq_ff;
  assign cap_irq_o = cap_irq_ff;
  assign tmo_irq_o = tmo_irq_ff;

  // ==========================================================
  // assertions
  sequence s_wrap_seen;
    t16_wrap && !smr_recover_i;
  endsequence

  a_shared_rsvd_ones: assert property (@(posedge clk_i) disable iff (srst_i)
    rd_i && bank_hit && reg_sel == dct_pkg::OFS_SHARED_CTL
    |=> rdata_o[4:0] == 5'h1f) else $error("reserved bits not ones");
  a_idle_out_level: assert property (@(posedge clk_i) disable iff (srst_i)
    !timer8_control_ff[7] |=> short_counter_output_o ==
    !$past(timer_io_control_ff[1])) else $error("idle level wrong");
  a_t8_flag_set: assert property (@(posedge clk_i) disable iff (srst_i)
    t8_to && !smr_recover_i |=> timer8_control_ff[5])
    else $error("t8 flag not set");
  a_single_pass_stop: assert property (@(posedge clk_i) disable iff (srst_i)
    t8_to && timer8_control_ff[6] && !smr_recover_i
    |=> !timer8_control_ff[7]) else $error("single pass kept running");
  a_t16_wrap_max: assert property (@(posedge clk_i) disable iff (srst_i)
    s_wrap_seen |=> long_counter_ff == 16'hffff && timer16_control_ff[5])
    else $error("wrap wrong");
  a_wrap_irq: assert property (@(posedge clk_i) disable iff (srst_i)
    s_wrap_seen ##0 timer16_control_ff[1] |=> tmo_irq_o)
    else $error("timeout irq missing");
  a_t8_capture_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    t8_cap |=> {timer16_high_hold_ff, timer16_low_hold_ff} ==
    $past(long_counter_ff) && !$past(edge_cap))
    else $error("t8 capture wrong");
  a_edge_reload: assert property (@(posedge clk_i) disable iff (srst_i)
    edge_cap |=> long_counter_ff == 16'hffff && (!arm_ff || $past(wr_i)))
    else $error("edge reload wrong");
  a_ignore_edges: assert property (@(posedge clk_i) disable iff (srst_i)
    edge_sel && t16_run && timer16_control_ff[6] && !arm_ff |=>
    long_counter_ff == $past(long_counter_ff) - 16'($past(base_tick)))
    else $error("edge not ignored");
endmodule : dct_timer

// file: tb/dct_carrier_model.sv
`timescale 1ns/100ps
module dct_carrier_model (
  // timing
  input wire logic clk_i,
  // burst request
  input wire logic go_i,
  input wire logic [7:0] width_i,
  // carrier toward the capture pin
  output logic carrier_o
);
  logic [7:0] left_ff = 8'h00;
  // no carrier between bursts, so the line rests low
  always_ff @(posedge clk_i) begin
    if (go_i) begin
      left_ff <= width_i;
    end else if (left_ff != 8'h00) begin
      left_ff <= left_ff - 8'h01;
    end
  end
  assign carrier_o = (left_ff != 8'h00);
endmodule : dct_carrier_model

// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic wr_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic smr_recover_i = 1'b0;
  logic sclk_div16_i = 1'b0;
  logic cap_in_i;
  logic short_counter_output_o;
  logic t8_irq_o;
  logic cap_irq_o;
  logic tmo_irq_o;
  logic go = 1'b0;
  logic [7:0] width = 8'h00;
  logic [7:0] r;
  int error_cnt = 0;
  int total_checks = 0;
  int n_t8 = 0;
  int n_cap = 0;
  int n_tmo = 0;

  always #5 clk_i = ~clk_i;

  dct_timer dut (.clk_i, .srst_i, .addr_i, .wr_i, .wdata_i, .rd_i,
    .rdata_o, .smr_recover_i, .sclk_div16_i, .cap_in_i,
    .short_counter_output_o, .t8_irq_o, .cap_irq_o, .tmo_irq_o);

  dct_carrier_model carrier (.clk_i, .go_i(go), .width_i(width),
    .carrier_o(cap_in_i));

  // irq pulses last one cycle, so they are tallied here
  always @(posedge clk_i) begin
    if (t8_irq_o === 1'b1) n_t8 <= n_t8 + 1;
    if (cap_irq_o === 1'b1) n_cap <= n_cap + 1;
    if (tmo_irq_o === 1'b1) n_tmo <= n_tmo + 1;
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    #1 r = rdata_o;
  endtask : rd

  task automatic burst(input logic [7:0] w);
    @(posedge clk_i);
    width <= w;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask : burst

  task automatic gap(output int n);
    logic l;
    l = short_counter_output_o;
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (short_counter_output_o === l && n < 4000);
  endtask : gap

  task automatic wait_irq(ref int c, input int lim, output int n);
    int b;
    b = c;
    n = 0;
    while (c == b && n < lim) begin
      @(posedge clk_i);
      #1 n++;
    end
  endtask : wait_irq

  task automatic cap(output logic [15:0] v);
    int n;
    wait_irq(n_cap, 200, n);
    rd(8'h06);
    v[7:0] = r;
    rd(8'h07);
    v[15:8] = r;
  endtask : cap

  // ==========================================================
  // scenarios
  task automatic t_regs();
    rd(8'hfd);
    chk(8'h00, r);
    chk(1, short_counter_output_o);
    wr(8'hfd, 8'h0d);
    for (int i = 4; i < 7; i++) begin
      wr(i[7:0], 8'ha5 ^ i[7:0]);
      rd(i[7:0]);
      chk(8'ha5 ^ i[7:0], r);
    end
    rd(8'he4);
    chk(8'ha1, r);
    wr(8'h03, 8'h00);
    rd(8'h03);
    chk(5'h1f, r[4:0]);
    wr(8'h01, 8'h02);
    rd(8'h01);
    chk(0, short_counter_output_o);
    wr(8'h01, 8'h00);
    wr(8'hfd, 8'h00);
    rd(8'h05);
    chk(8'h00, r);
    wr(8'hfd, 8'h0d);
    wr(8'h00, 8'h5c);
    @(posedge clk_i);
    smr_recover_i <= 1'b1;
    @(posedge clk_i);
    smr_recover_i <= 1'b0;
    rd(8'h00);
    chk(8'h1c, r);
  endtask : t_regs

  task automatic t_short();
    int n;
    int d;
    int b;
    logic l;
    wr(8'h04, 8'd5);
    wr(8'h05, 8'd9);
    for (int i = 0; i < 5; i++) begin
      d = (i < 4) ? (1 << i) : 16;
      @(posedge clk_i);
      sclk_div16_i <= (i == 4);
      wr(8'h00, 8'h80 | 8'((i & 3) << 3));
      gap(n);
      l = short_counter_output_o;
      gap(n);
      chk(l ? 10 * d : 6 * d, n);
      wr(8'h00, 8'h00);
      rd(8'h00);
      chk(1, r[5]);
      wr(8'h00, 8'h20);
      rd(8'h00);
      chk(0, r[5]);
    end
    @(posedge clk_i);
    sclk_div16_i <= 1'b0;
    b = n_t8;
    wr(8'h00, 8'hc2);
    gap(n);
    gap(n);
    chk(1, n);
    gap(n);
    chk(4000, n);
    chk(b + 1, n_t8);
    wr(8'h00, 8'h20);
  endtask : t_short

  task automatic t_glitch();
    int n;
    int b;
    wr(8'h02, 8'h80);
    wr(8'h00, 8'h04);
    wr(8'h01, 8'h1c);
    b = n_cap;
    burst(8'd5);
    repeat (40) @(posedge clk_i);
    chk(b, n_cap);
    burst(8'd30);
    wait_irq(n_cap, 60, n);
    chk(1, cap_in_i);
    wr(8'h01, 8'h2c);
    burst(8'd30);
    wait_irq(n_cap, 80, n);
    chk(1, n < 80 && cap_in_i === 1'b0);
    b = n_cap;
    wr(8'h01, 8'h3c);
    burst(8'd30);
    repeat (80) @(posedge clk_i);
    chk(b + 2, n_cap);
    wr(8'h00, 8'h00);
    wr(8'h02, 8'h00);
  endtask : t_glitch

  task automatic t_demod();
    int n;
    logic [15:0] c0;
    logic [15:0] c1;
    wr(8'h01, 8'h10);
    wr(8'h04, 8'd39);
    wr(8'h05, 8'd39);
    wr(8'h02, 8'hc4);
    burst(8'd10);
    repeat (12) @(posedge clk_i);
    wr(8'h00, 8'h80);
    cap(c0);
    burst(8'd10);
    cap(c1);
    chk(40, c0 - c1);
    chk(8'hff, c0[15:8]);
    wr(8'h00, 8'h00);
    wr(8'h02, 8'h84);
    wr(8'h02, 8'hc4);
    // long idle so a missed reload leaves a low high byte
    repeat (1000) @(posedge clk_i);
    burst(8'd10);
    wr(8'h00, 8'h80);
    cap(c0);
    chk(8'hff, c0[15:8]);
    wr(8'h00, 8'h00);
    wr(8'h02, 8'hc2);
    wait_irq(n_tmo, 70000, n);
    chk(1, n > 65000 && n < 65600);
    rd(8'h02);
    chk(1, r[5]);
    wr(8'h02, 8'he4);
    rd(8'h02);
    chk(0, r[5]);
    wr(8'h00, 8'h80);
    cap(c0);
    chk(8'hff, c0[15:8]);
  endtask : t_demod

  task automatic summarize();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    t_regs();
    t_short();
    t_glitch();
    t_demod();
    summarize();
  end

  // the wrap wait alone is some 66k cycles
  initial begin
    #900000;
    error_cnt++;
    summarize();
  end
endmodule : tb
